/* File: design/delay_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module delay_ctrl
    import delay_ctrl_pkg::*;
(
    input  wire logic        pclk,          // 100 MHz
    input  wire logic        presetn,       // async, active low
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mode_btn,      // pulse, toggles bypass
    input  wire logic        start_btn,     // pulse, ramp up
    input  wire logic        exit_btn,      // pulse, ramp down
    input  wire logic        erase_btn,     // pulse, erase
    input  wire logic        hold_btn,      // level, hold
    input  wire logic        frame_tick,    // one pulse per audio frame
    input  wire logic [15:0] in_l,
    input  wire logic [15:0] in_r,
    input  wire logic [3:0]  relay_on,      // relay energized
    input  wire logic [3:0]  relay_cue,     // relay cued
    output logic             bypass_relay,  // high: hard pass-through
    output logic             rec_en,        // write input to memory
    output logic             play_en,       // read a frame from memory
    output logic             play_mute,     // output muted
    output logic [DLY_W-1:0] delay_frames,
    output logic [8:0]       delay_tenths,
    output logic [5:0]       meter_l,
    output logic [5:0]       meter_r,
    output logic [7:0]       automation_relay_indicators, // {red,green} per relay
    output logic [6:0]       status,
    output logic             irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // ramp machine, one-hot codes
    // idle keeps the delay where it is
    typedef enum logic [4:0] {
        M_IDLE  = 5'b00001,
        M_UP    = 5'b00010,
        M_DOWN  = 5'b00100,
        M_HOLD  = 5'b01000,
        M_ERASE = 5'b10000
    } mode_type;

    // all state in one record,
    // registered as a whole below
    typedef struct packed {
        logic             bypass;     // pass-through
        mode_type         mode;       // ramp machine
        logic [DLY_W-1:0] delay;      // stored frames
        logic [DLY_W-1:0] preset;     // target
        logic [DLY_W-1:0] erase_len;  // erase length
        logic [3:0]       phase;      // stretch phase
        logic             muted;
        logic [12:0]      tenth_cnt;  // unused, held at zero from reset
        logic [8:0]       tenths;     // readout
        logic [15:0]      pk_l;       // peak magnitudes
        logic [15:0]      pk_r;
        // meter bars, 0..40 segments
        logic [5:0]       bar_l;
        logic [5:0]       bar_r;
        logic [3:0]       irq_st;     // sticky events
        logic [3:0]       irq_mask;
        // bus read path
        logic [31:0]      rdata;
        logic             rvalid;     // read data ready
        logic             rec;
        logic             play;
    } state_type;

    // current and next copy
    state_type s_q;  // registered state
    state_type s_d;  // next state

    // magnitude of a sample
    // full negative stays at 16'h8000
    function automatic logic [15:0] mag(input logic [15:0] x);
        mag = x[15] ? 16'(~x + 16'h0001) : x;
    endfunction : mag

    // bar length: 1 dB per segment, approx 6 dB per octave bit
    // full scale is bit 14 of the magnitude, a full bar;
    // each lower bit takes about 6 segments off
    function automatic logic [5:0] bar(input logic [15:0] p);
        logic [5:0] b;
        b = 6'h00;
        for (int i = 0; i < 16; i++) begin
            if (p[i]) begin
                b = 6'((i * 6 - 44 > 0) ? i * 6 - 44 : 0);
            end
        end
        bar = (b > 6'(METER_MIN_DB)) ? 6'(METER_MIN_DB) : b;
    endfunction : bar

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // decode helpers
    logic access;   // apb access phase
    logic rd_first; // first read access cycle
    logic rd_irq;   // status read clears
    logic any_req;  // controls enabled, not in pass-through
    logic [3:0] ev; // events this cycle
    // one pass builds the next state
    // from buttons, bus and frame tick
    always_comb begin
        s_d      = s_q;
        ev       = 4'h0;
        access   = psel & penable;
        // a read answers one cycle late, so act once
        rd_first = access & ~pwrite & ~s_q.rvalid;
        rd_irq   = rd_first & (paddr == IRQ_OFF);
        // register writes, unmapped ones dropped
        if (access & pwrite) begin
            unique case (paddr)
                PRESET_OFF: begin
                    // preset capped at the maximum
                    s_d.preset = (pwdata[DLY_W-1:0] > DLY_W'(MAX_FRAMES)) ?
                                 DLY_W'(MAX_FRAMES) : pwdata[DLY_W-1:0];
                end
                ERASE_OFF: s_d.erase_len = pwdata[DLY_W-1:0];
                MASK_OFF:  s_d.irq_mask  = pwdata[3:0];
                default: ;
            endcase
        end
        // mode toggle, from button or software
        // acts in either mode
        if (mode_btn | (access & pwrite & (paddr == CTRL_OFF) & pwdata[0])) begin
            s_d.bypass = ~s_q.bypass;
        end
        // controls only act while processing
        any_req = ~s_q.bypass;
        if (any_req) begin
            // newest request wins, delay carried over
            // priority: erase, start, exit, hold
            // bus bits mirror the erase, start and exit buttons
            if (erase_btn | (access & pwrite & (paddr == CTRL_OFF) & pwdata[3])) begin
                s_d.mode = M_ERASE;
            end else if (start_btn | (access & pwrite & (paddr == CTRL_OFF) & pwdata[1])) begin
                s_d.mode = M_UP;
            end else if (exit_btn | (access & pwrite & (paddr == CTRL_OFF) & pwdata[2])) begin
                s_d.mode = M_DOWN;
            end else if (hold_btn && s_q.mode != M_HOLD) begin
                s_d.mode = M_HOLD;
            end
        end
        // per-frame delay movement
        // nothing moves between frames
        s_d.rec  = 1'b0;
        s_d.play = 1'b0;
        // one frame of audio per tick
        if (frame_tick) begin
            // stretch phase counts frames
            s_d.phase = 4'(s_q.phase + 4'h1);
            s_d.rec   = 1'b1;
            s_d.play  = 1'b1;
            if (s_q.bypass) begin
                s_d.rec  = 1'b0;
                s_d.play = 1'b0;
            end else begin
                unique case (s_q.mode)
                    // ramp up to preset
                    M_UP: begin
                        // stretch: skip a read every few frames
                        if (s_q.delay >= s_q.preset) begin
                            s_d.mode = M_IDLE;
                            ev[EV_REACHED] = 1'b1;
                        end else if (s_q.phase == 4'(STRETCH_EVERY - 1)) begin
                            s_d.play  = 1'b0;
                            s_d.delay = DLY_W'(s_q.delay + 1'b1);
                        end
                    end
                    // ramp down to zero
                    M_DOWN: begin
                        // compress: skip a write every few frames
                        if (s_q.delay == '0) begin
                            s_d.mode = M_IDLE;
                            ev[EV_ZERO] = 1'b1;
                        end else if (s_q.phase == 4'(STRETCH_EVERY - 1)) begin
                            s_d.rec   = 1'b0;
                            s_d.delay = DLY_W'(s_q.delay - 1'b1);
                        end
                    end
                    // input paused, output drains memory
                    M_HOLD: begin
                        s_d.rec = 1'b0;
                        if (s_q.delay == '0) begin
                            s_d.play  = 1'b0;
                            if (!s_q.muted) ev[EV_MUTE] = 1'b1;
                            s_d.muted = 1'b1;
                        end else begin
                            s_d.delay = DLY_W'(s_q.delay - 1'b1);
                        end
                        if (!hold_btn) begin
                            s_d.mode  = M_UP;
                            s_d.muted = 1'b0;
                        end
                    end
                    // erase lands on the next frame
                    M_ERASE: begin
                        // drop the newest audio, splice, rebuild
                        s_d.delay = (s_q.delay > s_q.erase_len) ?
                                    DLY_W'(s_q.delay - s_q.erase_len) : '0;
                        s_d.mode  = M_UP;
                        ev[EV_ERASE] = 1'b1;
                    end
                    default: ;
                endcase
            end
            // tenths readout tracks delay
            // uses the new delay, no lag
            s_d.tenths = 9'(s_d.delay / DLY_W'(TENTH_FRAMES));
            // peak hold and decay per frame
            // bars follow last frame's peak
            s_d.pk_l  = (mag(in_l) > s_q.pk_l) ? mag(in_l) : 16'(s_q.pk_l - (s_q.pk_l >> 8));
            s_d.pk_r  = (mag(in_r) > s_q.pk_r) ? mag(in_r) : 16'(s_q.pk_r - (s_q.pk_r >> 8));
            s_d.bar_l = bar(s_q.pk_l);
            s_d.bar_r = bar(s_q.pk_r);
        end
        // pass-through drops any ramp
        if (s_q.bypass) begin
            s_d.mode  = M_IDLE;
            s_d.muted = 1'b0;
        end
        // sticky events: set wins over read clear
        // events of this very cycle survive
        s_d.irq_st = (rd_irq ? 4'h0 : s_q.irq_st) | ev;
        // read data: captured in the first access cycle,
        // then held through the answer cycle and after
        s_d.rvalid = rd_first;
        if (rd_first) begin
            unique case (paddr)
                PRESET_OFF: s_d.rdata = 32'(s_q.preset);
                ERASE_OFF:  s_d.rdata = 32'(s_q.erase_len);
                STATE_OFF:  s_d.rdata = {24'h0, s_q.bypass, status};
                DELAY_OFF:  s_d.rdata = {2'h0, s_q.tenths, s_q.delay};
                RELAY_OFF:  s_d.rdata = {24'h0, relay_cue, relay_on};
                IRQ_OFF:    s_d.rdata = {28'h0, s_q.irq_st};
                MASK_OFF:   s_d.rdata = {28'h0, s_q.irq_mask};
                METER_OFF:  s_d.rdata = {16'h0, 2'h0, s_q.bar_r, 2'h0, s_q.bar_l};
                // unmapped reads give zero
                default:    s_d.rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // async clear to constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q           <= '0;
            s_q.mode      <= M_IDLE;
            s_q.preset    <= PRESET_RST;
            s_q.erase_len <= ERASE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // one status code, first match wins
    always_comb begin
        if (s_q.bypass)                    status = ST_BYPASSED;
        else if (s_q.muted)                status = ST_MUTED;
        else if (s_q.mode == M_HOLD)       status = ST_WAITING;
        else if (s_q.mode == M_UP)         status = ST_ADDING;
        else if (s_q.mode == M_DOWN)       status = ST_REDUCING;
        else if (s_q.delay == '0)          status = ST_REMOVED;
        else                               status = ST_MAXIMUM;
    end
    // relay lamps: red when cued, green when energized and not cued
    // two lamp bits per relay
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            automation_relay_indicators[2*i]   = relay_on[i] & ~relay_cue[i];
            automation_relay_indicators[2*i+1] = relay_cue[i];
        end
    end
    // registered state straight out, irq masked by irq_mask
    assign bypass_relay = s_q.bypass;
    assign rec_en       = s_q.rec;
    assign play_en      = s_q.play;
    assign play_mute    = s_q.muted;
    assign delay_frames = s_q.delay;
    assign delay_tenths = s_q.tenths;
    assign meter_l      = s_q.bar_l;
    assign meter_r      = s_q.bar_r;
    assign irq          = |(s_q.irq_st & s_q.irq_mask);
    assign prdata       = s_q.rdata;
    // writes answer at once, reads one wait state later
    assign pready       = psel & penable & (pwrite | s_q.rvalid);
    assign pslverr      = 1'b0;
endmodule : delay_ctrl
`default_nettype wire

/* File: design/delay_ctrl_pkg.sv */
//
// Contract
// - mode button toggles pass-through and processing
// - pass-through ignores all panel and remote controls except the mode toggle
// - processing routes audio through delay path
// - store up to 40 s, build by stretching
// - ramp-up steps delay to preset, capped 40 s
// - ramp-down compresses delay step by step to zero
// - hold pauses recording, plays memory, rebuilds after
// - hold outlasting stored delay mutes the output
// - erase drops preset recent audio, then ramps up
// - show accumulated delay in tenths of seconds
// - four relay indicators: off, green, red cued
// - two peak bars, 1 dB steps, -40..0 dBfs; bars move 6 segments per magnitude bit
// - report operating state among seven status codes
//
package delay_ctrl_pkg;
    // ------------------------------------------------------------
    // timing and sizes
    // ------------------------------------------------------------
    localparam int unsigned SAMPLE_RATE_HZ = 48000;                  // audio frame rate
    localparam int unsigned MAX_DELAY_S    = 40;                     // longest delay
    localparam int unsigned MAX_FRAMES     = MAX_DELAY_S * SAMPLE_RATE_HZ;
    localparam int unsigned DLY_W          = 21;                     // frame count width
    localparam int unsigned TENTH_FRAMES   = SAMPLE_RATE_HZ / 10;    // frames per 0.1 s
    localparam int unsigned STRETCH_EVERY  = 16;                     // stretch ratio
    localparam int unsigned METER_MIN_DB   = 40;                     // meter floor, -dB
    // ------------------------------------------------------------
    // register map (apb byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF    = 8'h00;  // w1 pulses: mode,start,exit,erase
    localparam logic [7:0] PRESET_OFF  = 8'h04;  // preset delay, frames
    localparam logic [7:0] ERASE_OFF   = 8'h08;  // erase length, frames
    localparam logic [7:0] STATE_OFF   = 8'h0c;  // status code, bypass
    localparam logic [7:0] DELAY_OFF   = 8'h10;  // delay frames / tenths
    localparam logic [7:0] RELAY_OFF   = 8'h14;  // energized[3:0], cued[7:4]
    localparam logic [7:0] IRQ_OFF     = 8'h18;  // sticky events, read clears
    localparam logic [7:0] MASK_OFF    = 8'h1c;  // interrupt mask
    localparam logic [7:0] METER_OFF   = 8'h20;  // bar lengths ch1, ch2
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DLY_W-1:0] PRESET_RST = DLY_W'(MAX_FRAMES);
    localparam logic [DLY_W-1:0] ERASE_RST  = DLY_W'(5 * SAMPLE_RATE_HZ);
    // ------------------------------------------------------------
    // status codes
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_BYPASSED = 7'b0000001,
        ST_REMOVED  = 7'b0000010,
        ST_ADDING   = 7'b0000100,
        ST_REDUCING = 7'b0001000,
        ST_WAITING  = 7'b0010000,
        ST_MUTED    = 7'b0100000,
        ST_MAXIMUM  = 7'b1000000
    } status_type;
    // event bits of the interrupt status
    localparam int unsigned EV_REACHED = 0;  // preset reached
    localparam int unsigned EV_ZERO    = 1;  // delay gone
    localparam int unsigned EV_MUTE    = 2;  // output muted
    localparam int unsigned EV_ERASE   = 3;  // erase done
endpackage : delay_ctrl_pkg

/* File: tb/audio_source.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// far side: audio source with a steady frame rate
// ------------------------------------------------------------
module audio_source #(
    parameter int TICK_DIV = 4                  // clocks per audio frame
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] amp_l,             // level asked by the bench
    input  wire logic [15:0] amp_r,
    output logic             frame_tick,
    output logic [15:0]      in_l,
    output logic [15:0]      in_r
);
    int cnt;                                    // clocks since last frame
    // frame strobe and samples move together just after the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt        <= 0;
            frame_tick <= 1'b0;
            in_l       <= 16'h0000;
            in_r       <= 16'h0000;
        end else begin
            cnt        <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
            frame_tick <= (cnt == TICK_DIV - 1);
            in_l       <= amp_l;
            in_r       <= amp_r;
        end
    end
endmodule : audio_source
`default_nettype wire

/* File: tb/delay_ctrl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// port checker for the delay control block
// ------------------------------------------------------------
module delay_ctrl_chk
    import delay_ctrl_pkg::*;
(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             hold_btn,
    input wire logic [3:0]       relay_on,
    input wire logic [3:0]       relay_cue,
    input wire logic             bypass_relay,
    input wire logic             rec_en,
    input wire logic             play_en,
    input wire logic             play_mute,
    input wire logic [DLY_W-1:0] delay_frames,
    input wire logic [8:0]       delay_tenths,
    input wire logic [5:0]       meter_l,
    input wire logic [5:0]       meter_r,
    input wire logic [7:0]       automation_relay_indicators,
    input wire logic [6:0]       status
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_comb: assert property (pready == (psel && penable
        && (pwrite || $past(psel && penable && !pwrite && !pready))))
        else $error("pready out of step with the access");
    a_no_error: assert property (!pslverr)
        else $error("pslverr raised");
    a_bypass_shown: assert property (bypass_relay == (status == ST_BYPASSED))
        else $error("bypass relay and status disagree");
    a_bypass_frozen: assert property (bypass_relay && $past(bypass_relay) |-> $stable(delay_frames))
        else $error("delay moved during pass-through");
    a_hold_norec: assert property (hold_btn && $past(hold_btn) && $past(hold_btn, 2)
        && !bypass_relay |-> !rec_en)
        else $error("recording during hold");
    a_gradual_grow: assert property (delay_frames > $past(delay_frames)
        |-> delay_frames == $past(delay_frames) + 1'b1)
        else $error("delay grew by more than one frame");
    a_delay_cap: assert property (delay_frames <= DLY_W'(MAX_FRAMES))
        else $error("delay above the maximum");
    a_mute_empty: assert property (play_mute |-> delay_frames == '0)
        else $error("muted with delay left");
    a_mute_silent: assert property (play_mute |-> !play_en)
        else $error("playing while muted");
    a_tenth_view: assert property ($stable(delay_frames) && $past(delay_frames) == $past(delay_frames, 2)
        |-> delay_tenths == 9'(delay_frames / TENTH_FRAMES))
        else $error("tenths readout wrong");
    a_relay_colour: assert property ((relay_on & relay_cue) == 4'h0 |-> automation_relay_indicators ==
        {relay_cue[3], relay_on[3], relay_cue[2], relay_on[2],
         relay_cue[1], relay_on[1], relay_cue[0], relay_on[0]})
        else $error("relay indicator wrong");
    a_meter_range: assert property (meter_l <= 6'(METER_MIN_DB) && meter_r <= 6'(METER_MIN_DB))
        else $error("meter beyond range");
    a_status_onehot: assert property ($onehot(status))
        else $error("status not one code");
endmodule : delay_ctrl_chk
bind delay_ctrl delay_ctrl_chk u_chk (.*);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import delay_ctrl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_btn, frame_tick;
    logic bypass_relay, rec_en, play_en, play_mute, irq;
    logic [7:0] paddr, automation_relay_indicators;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] btn, relay_on, relay_cue;       // mode, start, exit, erase
    logic [15:0] in_l, in_r, amp_l, amp_r;
    logic [DLY_W-1:0] delay_frames;
    logic [8:0] delay_tenths;
    logic [5:0] meter_l, meter_r;
    logic [6:0] status;
    int err_count, n_checks, cycles;
    logic [7:0] exp_ind;
    logic a_irq;
    // ------------------------------------------------------------
    // block, far side, clock and watchdog
    // ------------------------------------------------------------
    delay_ctrl dut (.mode_btn(btn[0]), .start_btn(btn[1]), .exit_btn(btn[2]), .erase_btn(btn[3]), .*);
    audio_source u_src (.*);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            results();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        logic rdy;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // sample mid-cycle what the next rising edge will see
        do begin
            @(negedge pclk);
            rdy = pready;
            rd  = prdata;
            @(posedge pclk);
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic pulse(input int i);
        btn[i] <= 1'b1;
        @(posedge pclk);
        btn[i] <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
    endtask : pulse
    task automatic wait_dly(input logic [DLY_W-1:0] t);
        int n;
        n = 0;
        while (delay_frames !== t && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        check("delay_frames", 32'(delay_frames), 32'(t));
    endtask : wait_dly
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("status", 32'(status), 32'(ST_REMOVED));
        apb(1'b0, PRESET_OFF, 32'h0);
        check("preset", rd, 32'h001d4c00);
        apb(1'b0, ERASE_OFF, 32'h0);
        check("erase", rd, 32'h0003a980);
        apb(1'b1, 8'h24, 32'hffffffff);
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask : t_reset
    task automatic t_ramp_up();
        apb(1'b1, PRESET_OFF, 32'h3);
        pulse(1);
        check("status", 32'(status), 32'(ST_ADDING));
        wait_dly(3);
        repeat (8) @(posedge pclk);
        check("status", 32'(status), 32'(ST_MAXIMUM));
        a_irq = irq;
        apb(1'b1, MASK_OFF, 32'hf);
        check("irq mask", 32'(a_irq ^ irq), 32'h1);
        apb(1'b0, IRQ_OFF, 32'h0);
        check("irq reached", rd & 32'h1, 32'h1);
        check("irq cleared", 32'(irq), 32'h0);
    endtask : t_ramp_up
    task automatic t_abort();
        pulse(2);
        wait_dly(2);
        pulse(1);
        check("abort delay", 32'(delay_frames), 32'h2);
        check("abort status", 32'(status), 32'(ST_ADDING));
        wait_dly(3);
    endtask : t_abort
    task automatic t_hold();
        hold_btn <= 1'b1;
        wait_dly(0);
        repeat (12) @(posedge pclk);
        check("mute", 32'(play_mute), 32'h1);
        hold_btn <= 1'b0;
        wait_dly(3);
        apb(1'b0, IRQ_OFF, 32'h0);
        check("irq mute", (rd >> 2) & 32'h1, 32'h1);
    endtask : t_hold
    task automatic t_erase();
        apb(1'b1, ERASE_OFF, 32'h2);
        pulse(3);
        wait_dly(1);
        wait_dly(3);
        apb(1'b0, IRQ_OFF, 32'h0);
        check("irq erase", (rd >> 3) & 32'h1, 32'h1);
    endtask : t_erase
    task automatic t_down();
        apb(1'b1, CTRL_OFF, 32'h4);
        check("status", 32'(status), 32'(ST_REDUCING));
        wait_dly(0);
        repeat (8) @(posedge pclk);
        check("status", 32'(status), 32'(ST_REMOVED));
    endtask : t_down
    task automatic t_bypass();
        pulse(1);
        wait_dly(2);
        pulse(0);
        check("bypass", 32'(bypass_relay), 32'h1);
        pulse(2);
        repeat (200) @(posedge pclk);
        check("status", 32'(status), 32'(ST_BYPASSED));
        check("frozen", 32'(delay_frames), 32'h2);
        apb(1'b0, STATE_OFF, 32'h0);
        check("state reg", rd, 32'h81);
        apb(1'b0, DELAY_OFF, 32'h0);
        check("delay reg", rd, 32'h2);
        apb(1'b1, CTRL_OFF, 32'h1);
        check("bypass", 32'(bypass_relay), 32'h0);
        pulse(2);
        wait_dly(0);
    endtask : t_bypass
    task automatic t_meter_relay();
        amp_l <= 16'h7fff;
        repeat (40) @(posedge pclk);
        check("meter_l", 32'(meter_l), 32'(METER_MIN_DB));
        check("meter_r", 32'(meter_r), 32'h0);
        apb(1'b0, METER_OFF, 32'h0);
        check("meter reg", rd, 32'h28);
        for (int i = 0; i < 4; i++) begin
            relay_on  <= 4'h1 << i;
            relay_cue <= 4'h1 << ((i + 1) % 4);
            exp_ind = (8'h1 << (2 * i)) | (8'h2 << (2 * ((i + 1) % 4)));
            @(posedge pclk);
            @(posedge pclk);
            check("relays", 32'(automation_relay_indicators), 32'(exp_ind));
        end
        apb(1'b0, RELAY_OFF, 32'h0);
        check("relay reg", rd, 32'h18);
    endtask : t_meter_relay
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, hold_btn} = '0;
        {paddr, pwdata, btn, relay_on, relay_cue, amp_l, amp_r} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_ramp_up();
        t_abort();
        t_hold();
        t_erase();
        t_down();
        t_bypass();
        t_meter_relay();
        results();
    end
endmodule : testbench
`default_nettype wire
